//--- logic/ccpu_pkg.sv
// Purpose: Shared constants and types of the capture/compare/PWM unit
// Assumes: 16-bit register port, 3-bit register address
// Notes:   Field layouts are packed structs so no bit position is bare
package ccpu_pkg;

	// ---------------------------------------------------------------
	// Register port geometry and map
	// ---------------------------------------------------------------
	localparam int         DATA_W   = 16;   // Register data width
	localparam int         ADDR_W   = 3;    // Register address width
	localparam logic [2:0] REG_CTRL = 3'h0; // unit_control_register
	localparam logic [2:0] REG_VLO  = 3'h1; // capture_value_low / duty MSBs
	localparam logic [2:0] REG_VHI  = 3'h2; // capture_value_high / duty buf
	localparam logic [2:0] REG_PER  = 3'h3; // pwm_period_register
	localparam logic [2:0] REG_TCON = 3'h4; // pwm_timer_control
	localparam logic [2:0] REG_TCNT = 3'h5; // pwm_timer_count, read only
	localparam logic [2:0] REG_TSEL = 3'h6; // timer_select_register
	localparam logic [2:0] REG_IRQ  = 3'h7; // Flag, enable, pin latch

	// ---------------------------------------------------------------
	// Mode field encodings (eight are defaults of the unit's parameters)
	// ---------------------------------------------------------------
	localparam logic [3:0] MODE_OFF    = 4'h0; // Unit off, pin released
	localparam logic [3:0] MODE_CMP_TG = 4'h2; // Compare, toggle pin
	localparam logic [3:0] MODE_CMP_LT = 4'h3; // Compare, pin follows latch
	localparam logic [3:0] MODE_CAP_F  = 4'h4; // Capture every falling edge
	localparam logic [3:0] MODE_CAP_R  = 4'h5; // Capture every rising edge
	localparam logic [3:0] MODE_CAP_R4 = 4'h6; // Every 4th rising edge
	localparam logic [3:0] MODE_CAP_RG = 4'h7; // Every 16th rising edge
	localparam logic [3:0] MODE_CMP_HI = 4'h8; // Compare, drive pin high
	localparam logic [3:0] MODE_CMP_LO = 4'h9; // Compare, drive pin low
	localparam logic [3:0] MODE_CMP_SW = 4'ha; // Compare, interrupt only
	localparam logic [3:0] MODE_CMP_SE = 4'hb; // Compare, special event
	localparam logic [3:0] MODE_PWM    = 4'hc; // PWM (upper two bits 11)
	localparam logic [1:0] PWM_TOP     = 2'h3; // Mode bits 3:2 for PWM

	// ---------------------------------------------------------------
	// Prescaler and counter limits, reset values
	// ---------------------------------------------------------------
	localparam logic [3:0] PRE1_LIM  = 4'h0; // Timer prescale 1
	localparam logic [3:0] PRE4_LIM  = 4'h3; // Timer prescale 4
	localparam logic [3:0] PRE16_LIM = 4'hf; // Timer prescale 16
	localparam logic [1:0] QMAX      = 2'h3; // Last quarter step
	localparam logic [3:0] CAP4_LIM  = 4'h3; // Edge count for 4th edge
	localparam logic [3:0] CAP16_LIM = 4'hf; // Edge count for 16th edge
	localparam logic [7:0] RST_PER   = 8'hff; // Period register reset

	// ---------------------------------------------------------------
	// Register layouts and carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0] dutyLowBits; // Two duty LSBs
		logic [3:0] mode;        // unit_mode_field
	} ccpu_ctrl_s;

	typedef struct packed {
		logic [3:0] post;  // Postscale, events minus one
		logic       on;    // Timer run
		logic [1:0] pre;   // 00 = 1, 01 = 4, 1x = 16
	} ccpu_tcon_s;

	typedef struct packed {
		logic latch;  // Pin latch for compare-latch mode
		logic enable; // unit_irq_enable
		logic flag;   // unit_irq_flag
	} ccpu_irq_s;

	typedef struct packed {
		logic [7:0] count;    // pwm_timer_count
		logic [1:0] quarter;  // Quarter-step extension
		logic       rollover; // Pulse: count just cleared on period
	} ccpu_base_s;

endpackage : ccpu_pkg

//--- logic/ccpu_time_base.sv
// Purpose: Period-register timer with prescaler and postscaler for PWM
// Assumes: One sys_clk is one quarter step at prescale 1
// Notes:   Postscaler output never feeds back into the period
`timescale 1ns/10ps
`default_nettype none
module ccpu_time_base (
	input  wire logic              sys_clk,   // System clock
	input  wire logic              nrst,      // Async reset, active low
	input  wire ccpu_pkg::ccpu_tcon_s tcon,   // Timer control
	input  wire logic [7:0]        period,    // pwm_period_register
	output ccpu_pkg::ccpu_base_s   base,      // Count and rollover
	output logic                   postEvent  // Postscaled period pulse
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [3:0]           pre;  // Prescale divider
		logic [3:0]           post; // Postscale counter
		logic                 postEv;
		ccpu_pkg::ccpu_base_s b;
	} ccpu_tb_s;

	ccpu_tb_s s;       // Registered state
	ccpu_tb_s next_s;  // Next state

	// Prescale limit from the two select bits
	function automatic logic [3:0] preLimit(input logic [1:0] sel);
		unique case (sel)
			2'h0:    preLimit = ccpu_pkg::PRE1_LIM;
			2'h1:    preLimit = ccpu_pkg::PRE4_LIM;
			default: preLimit = ccpu_pkg::PRE16_LIM;
		endcase
	endfunction : preLimit

	// Count quarter steps; clear on the step after the period match
	always_comb begin
		next_s = s;
		next_s.b.rollover = 1'b0;
		next_s.postEv = 1'b0;
		if (!tcon.on) begin
			next_s.pre = '0;
		end else if (s.pre < preLimit(tcon.pre)) begin
			next_s.pre = s.pre + 4'h1;
		end else begin
			next_s.pre = '0;
			if (s.b.count == period && s.b.quarter == ccpu_pkg::QMAX) begin
				next_s.b.count = '0;
				next_s.b.quarter = '0;
				next_s.b.rollover = 1'b1;
				// Postscaler only counts periods, it never shortens them
				if (s.post == tcon.post) begin
					next_s.post = '0;
					next_s.postEv = 1'b1;
				end else begin
					next_s.post = s.post + 4'h1;
				end
			end else begin
				next_s.b.quarter = s.b.quarter + 2'h1;
				if (s.b.quarter == ccpu_pkg::QMAX) begin
					next_s.b.count = s.b.count + 8'h01;
				end
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign base = s.b;
	assign postEvent = s.postEv;

endmodule : ccpu_time_base
`default_nettype wire

//--- logic/ccpu_unit.sv
// Purpose: Capture/compare/PWM unit with register port and one pin
// Assumes: Pin and timer inputs are synchronous to sys_clk
// Notes:   Read data appear in the cycle after the read strobe
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ccpu_unit #(
	parameter logic [3:0] M_CMP_TG = ccpu_pkg::MODE_CMP_TG, // Toggle
	parameter logic [3:0] M_CMP_LT = ccpu_pkg::MODE_CMP_LT, // Latch
	parameter logic [3:0] M_CAP_F  = ccpu_pkg::MODE_CAP_F,  // Falling
	parameter logic [3:0] M_CAP_R  = ccpu_pkg::MODE_CAP_R,  // Rising
	parameter logic [3:0] M_CAP_R4 = ccpu_pkg::MODE_CAP_R4, // 4th rise
	parameter logic [3:0] M_CAP_RG = ccpu_pkg::MODE_CAP_RG, // 16th rise
	parameter logic [3:0] M_CMP_HI = ccpu_pkg::MODE_CMP_HI, // Set pin
	parameter logic [3:0] M_CMP_LO = ccpu_pkg::MODE_CMP_LO  // Clear pin
) (
	input  wire logic        sys_clk,      // System clock, 200 MHz
	input  wire logic        nrst,         // Async reset, active low
	input  wire logic [2:0]  regAddr,      // Register address
	input  wire logic [15:0] regWdata,     // Register write data
	input  wire logic        regWr,        // Write strobe
	input  wire logic        regRd,        // Read strobe
	output logic      [15:0] regRdata,     // Read data, one cycle later
	input  wire logic [15:0] timerCountA,  // 16-bit timer, select 0
	input  wire logic [15:0] timerCountB,  // 16-bit timer, select 1
	output logic             timerSelect,  // Which timer is assigned
	output logic             timerClear,   // Clear assigned timer, pulse
	output logic             specialEvent, // Trigger to peers, pulse
	output logic             postEvent,    // PWM timer postscaled pulse
	input  wire logic        unitPinIn,    // unit_pin input level
	output logic             unitPinOut,   // unit_pin drive level
	output logic             unitPinOe,    // unit_pin output enable
	output logic             unitIrq       // Flag gated by enable
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		ccpu_pkg::ccpu_ctrl_s ctrl;     // unit_control_register
		logic [7:0]           valLow;   // capture_value_low
		logic [7:0]           valHigh;  // capture_value_high
		logic [7:0]           period;   // pwm_period_register
		ccpu_pkg::ccpu_tcon_s tcon;     // pwm_timer_control
		logic                 tsel;     // timer_select_register
		ccpu_pkg::ccpu_irq_s  irq;      // Flag, enable, latch
		logic                 pinPrev;  // Pin level one cycle ago
		logic [3:0]           edgeCnt;  // Capture edge prescaler
		logic                 cmpEq;    // Compare equality last cycle
		logic                 pin;      // Driven pin level
		logic [1:0]           dutyLsb;  // Two-bit duty latch
		logic                 special;  // Special event pulse
		logic [15:0]          rdata;    // Read data register
	} ccpu_state_s;

	ccpu_state_s s;        // Registered state
	ccpu_state_s next_s;   // Next state

	ccpu_pkg::ccpu_base_s base;     // PWM time base
	logic                 postPulse; // Postscaler output
	logic [15:0]          selTimer;  // Assigned 16-bit timer
	logic                 riseEdge;  // Rising edge on the pin
	logic                 fallEdge;  // Falling edge on the pin
	logic                 capEvent;  // Selected capture event
	logic                 cmpHit;    // First cycle of a compare match
	logic [9:0]           dutyNew;   // Software duty value

	// ---------------------------------------------------------------
	// Mode decoding
	// ---------------------------------------------------------------
	function automatic logic isCapture(input logic [3:0] m);
		isCapture = (m == M_CAP_F) || (m == M_CAP_R) ||
			(m == M_CAP_R4) || (m == M_CAP_RG);
	endfunction : isCapture

	function automatic logic isPwm(input logic [3:0] m);
		isPwm = (m[3:2] == ccpu_pkg::PWM_TOP);
	endfunction : isPwm

	function automatic logic isCompare(input logic [3:0] m);
		isCompare = (m == M_CMP_TG) || (m == M_CMP_LT) ||
			(m == M_CMP_HI) || (m == M_CMP_LO) ||
			(m == ccpu_pkg::MODE_CMP_SW) || (m == ccpu_pkg::MODE_CMP_SE);
	endfunction : isCompare

	// ---------------------------------------------------------------
	// PWM time base
	// ---------------------------------------------------------------
	// Own period-register timer, never the 16-bit capture timers
	ccpu_time_base u_base (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.tcon      (s.tcon),
		.period    (s.period),
		.base      (base),
		.postEvent (postPulse)
	);

	// ---------------------------------------------------------------
	// Event detection
	// ---------------------------------------------------------------
	// Assigned 16-bit timer; capture and compare share the choice
	assign selTimer = s.tsel ? timerCountB : timerCountA;
	assign riseEdge = unitPinIn & ~s.pinPrev;
	assign fallEdge = ~unitPinIn & s.pinPrev;
	// Rising duty of the 10-bit value: eight MSBs then two LSBs
	assign dutyNew = {s.valLow, s.ctrl.dutyLowBits};

	// Pick the capture event; 4th and 16th use the edge prescaler
	always_comb begin
		unique case (s.ctrl.mode)
			M_CAP_F:  capEvent = fallEdge;
			M_CAP_R:  capEvent = riseEdge;
			M_CAP_R4: capEvent = riseEdge &&
				((s.edgeCnt & ccpu_pkg::CAP4_LIM) == ccpu_pkg::CAP4_LIM);
			M_CAP_RG: capEvent = riseEdge &&
				(s.edgeCnt == ccpu_pkg::CAP16_LIM);
			default:  capEvent = 1'b0;
		endcase
	end

	// A match fires once when equality appears, not every cycle
	// that a stopped timer keeps the same count
	assign cmpHit = isCompare(s.ctrl.mode) &&
		(selTimer == {s.valHigh, s.valLow}) && !s.cmpEq;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.special = 1'b0;
		next_s.pinPrev = unitPinIn;
		next_s.cmpEq = selTimer == {s.valHigh, s.valLow};
		next_s.rdata = '0;

		// Software writes first; hardware events below override them
		if (regWr) begin
			unique case (regAddr)
				ccpu_pkg::REG_CTRL: next_s.ctrl = regWdata[5:0];
				ccpu_pkg::REG_VLO:  next_s.valLow = regWdata[7:0];
				ccpu_pkg::REG_VHI: begin
					// Duty buffer is not writable in PWM mode, even with the timer stopped
					if (!isPwm(s.ctrl.mode)) begin
						next_s.valHigh = regWdata[7:0];
					end
				end
				ccpu_pkg::REG_PER:  next_s.period = regWdata[7:0];
				ccpu_pkg::REG_TCON: next_s.tcon = regWdata[6:0];
				ccpu_pkg::REG_TSEL: next_s.tsel = regWdata[0];
				ccpu_pkg::REG_IRQ:  next_s.irq = regWdata[2:0];
				default: ;
			endcase
		end

		// Edge prescaler: held at zero unless capturing; a change
		// between capture modes keeps the count running
		if (!isCapture(next_s.ctrl.mode)) begin
			next_s.edgeCnt = '0;
		end else if (riseEdge && isCapture(s.ctrl.mode)) begin
			next_s.edgeCnt = s.edgeCnt + 4'h1;
		end

		// Capture: newest count wins over any unread one
		if (isCapture(s.ctrl.mode) && capEvent) begin
			next_s.valHigh = selTimer[15:8];
			next_s.valLow = selTimer[7:0];
			next_s.irq.flag = 1'b1;
		end

		// Compare: pin action and flag in the same edge
		if (cmpHit) begin
			next_s.irq.flag = 1'b1;
			unique case (s.ctrl.mode)
				M_CMP_HI: next_s.pin = 1'b1;
				M_CMP_LO: next_s.pin = 1'b0;
				M_CMP_TG: next_s.pin = ~s.pin;
				ccpu_pkg::MODE_CMP_SE: next_s.special = 1'b1;
				default: ; // Interrupt-only keeps the pin as it is
			endcase
		end
		if (s.ctrl.mode == M_CMP_LT) begin
			next_s.pin = s.irq.latch;
		end

		// PWM: load duty and set pin on rollover unless duty is zero, clear on duty match
		if (isPwm(s.ctrl.mode)) begin
			if (base.rollover) begin
				next_s.valHigh = dutyNew[9:2];
				next_s.dutyLsb = dutyNew[1:0];
				next_s.pin = (dutyNew != '0);
			end else if ({s.valHigh, s.dutyLsb} ==
				{base.count, base.quarter}) begin
				// A duty past the period never matches, pin stays high
				next_s.pin = 1'b0;
			end
		end else if (s.ctrl.mode == ccpu_pkg::MODE_OFF) begin
			next_s.pin = 1'b0;
		end

		// Read data, registered for the following cycle
		if (regRd) begin
			unique case (regAddr)
				ccpu_pkg::REG_CTRL: next_s.rdata = 16'(s.ctrl);
				ccpu_pkg::REG_VLO:  next_s.rdata = 16'(s.valLow);
				ccpu_pkg::REG_VHI:  next_s.rdata = 16'(s.valHigh);
				ccpu_pkg::REG_PER:  next_s.rdata = 16'(s.period);
				ccpu_pkg::REG_TCON: next_s.rdata = 16'(s.tcon);
				ccpu_pkg::REG_TCNT: next_s.rdata = 16'(base.count);
				ccpu_pkg::REG_TSEL: next_s.rdata = 16'(s.tsel);
				ccpu_pkg::REG_IRQ:  next_s.rdata = 16'(s.irq);
				default: next_s.rdata = '0;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s <= '{
				ctrl: '0, valLow: '0, valHigh: '0,
				period: ccpu_pkg::RST_PER, tcon: '0, tsel: 1'b0,
				irq: '0, pinPrev: 1'b0, edgeCnt: '0, cmpEq: 1'b0,
				pin: 1'b0, dutyLsb: '0, special: 1'b0, rdata: '0
			};
		end else begin
			s <= next_s;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign regRdata = s.rdata;
	assign timerSelect = s.tsel;
	assign specialEvent = s.special;
	assign timerClear = s.special;
	assign postEvent = postPulse;
	assign unitPinOut = s.pin;
	// Drive in compare and PWM; capture and off leave the pin free
	assign unitPinOe = isCompare(s.ctrl.mode) || isPwm(s.ctrl.mode);
	assign unitIrq = s.irq.flag & s.irq.enable;

endmodule : ccpu_unit
`default_nettype wire

//--- sim/ccpu_checker.sv
// Purpose: Port-level checks of the capture/compare/PWM unit
// Assumes: Default mode encodings of the package
// Notes:   Shadows of mode, compare value and enable follow the writes
`timescale 1ns/10ps
`default_nettype none
module ccpu_checker (
	input wire logic        sys_clk,      // System clock
	input wire logic        nrst,         // Async reset, active low
	input wire logic [2:0]  regAddr,      // Register address
	input wire logic [15:0] regWdata,     // Write data
	input wire logic        regWr,        // Write strobe
	input wire logic [15:0] timerCountA,  // Timer, select 0
	input wire logic [15:0] timerCountB,  // Timer, select 1
	input wire logic        timerSelect,  // Assigned timer
	input wire logic        timerClear,   // Timer clear pulse
	input wire logic        specialEvent, // Trigger pulse
	input wire logic        unitPinOut,   // Pin drive
	input wire logic        unitPinOe,    // Pin enable
	input wire logic        unitIrq       // Gated flag
);
	// ------------------------------------------------------------
	// Shadow state
	// ------------------------------------------------------------
	logic [3:0]  mode;   // Last written mode field
	logic [15:0] cmpVal; // Last written compare value
	logic        irqEn;  // Last written enable
	logic        irqWrQ; // Flag register written last cycle
	logic        hitQ;   // Equality one cycle ago
	logic        hit;    // Selected timer equals compare value
	logic        isCmp;  // Compare modes are 001x and 10xx
	logic        match;  // First cycle of equality
	assign hit = (timerSelect ? timerCountB : timerCountA) == cmpVal;
	assign isCmp = (mode[3:2] == 2'h2) || (mode[3:1] == 3'h1);
	assign match = hit && !hitQ;
	// Track writes the way the unit takes them
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mode <= ccpu_pkg::MODE_OFF;
			cmpVal <= '0;
			irqEn <= 1'b0;
			irqWrQ <= 1'b0;
			hitQ <= 1'b0;
		end else begin
			hitQ <= hit;
			irqWrQ <= regWr && regAddr == ccpu_pkg::REG_IRQ;
			if (regWr && regAddr == ccpu_pkg::REG_CTRL)
				mode <= regWdata[3:0];
			if (regWr && regAddr == ccpu_pkg::REG_VLO)
				cmpVal[7:0] <= regWdata[7:0];
			// High byte is read-only while in PWM
			if (regWr && regAddr == ccpu_pkg::REG_VHI && mode[3:2] != 2'h3)
				cmpVal[15:8] <= regWdata[7:0];
			if (regWr && regAddr == ccpu_pkg::REG_IRQ)
				irqEn <= regWdata[1];
		end
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	off_release_a: assert property (mode == 4'h0 && $past(mode) == 4'h0
		|-> !unitPinOe && !unitPinOut) else $error("pin not released");
	cmp_drive_a: assert property ((isCmp || mode[3:2] == 2'h3)
		|-> unitPinOe) else $error("pin not driven");
	evt_match_a: assert property (match && mode == 4'hb
		|=> specialEvent && timerClear) else $error("no trigger");
	set_match_a: assert property (match && mode == 4'h8
		|=> unitPinOut) else $error("pin not set");
	clr_match_a: assert property (match && mode == 4'h9
		|=> !unitPinOut) else $error("pin not cleared");
	tog_match_a: assert property (match && mode == 4'h2
		|=> unitPinOut != $past(unitPinOut)) else $error("no toggle");
	sw_keep_a: assert property (mode == 4'ha && $past(mode) == 4'ha
		|-> $stable(unitPinOut)) else $error("pin moved");
	irq_fall_a: assert property ($fell(unitIrq) |-> irqWrQ)
		else $error("flag cleared by hardware");
	cmp_flag_a: assert property (match && isCmp && irqEn
		|=> unitIrq) else $error("flag not set on match");
endmodule : ccpu_checker

bind ccpu_unit ccpu_checker chk (.sys_clk(sys_clk), .nrst(nrst),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
	.timerCountA(timerCountA), .timerCountB(timerCountB),
	.timerSelect(timerSelect), .timerClear(timerClear),
	.specialEvent(specialEvent), .unitPinOut(unitPinOut),
	.unitPinOe(unitPinOe), .unitIrq(unitIrq));
`default_nettype wire

//--- sim/ccpu_partner.sv
// Purpose: Two timers and the outside pin facing the unit
// Assumes: Timers count synchronously on sys_clk
// Notes:   Timer B wraps at 8'hff so compare matches recur quickly
`timescale 1ns/10ps
`default_nettype none
module ccpu_partner (
	input  wire logic        sys_clk,     // System clock
	input  wire logic        nrst,        // Async reset, active low
	input  wire logic        timerSelect, // Timer owned by the unit
	input  wire logic        timerClear,  // Clear the owned timer
	input  wire logic        pinDrive,    // Level driven from outside
	input  wire logic        unitPinOut,  // Unit drive level
	input  wire logic        unitPinOe,   // Unit drive enable
	output logic      [15:0] timerCountA, // Free-running timer
	output logic      [15:0] timerCountB, // Short-wrap timer
	output logic             unitPinIn    // Resolved pin level
);
	// Start value is arbitrary; it fills the high byte of captures
	localparam logic [15:0] A_START = 16'ha5c0;
	// Resolved wire: the unit wins while it drives
	assign unitPinIn = unitPinOe ? unitPinOut : pinDrive;
	// Synchronous counter mode, clear honoured on the owned timer
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			timerCountA <= A_START;
			timerCountB <= '0;
		end else begin
			timerCountA <= (timerClear && !timerSelect) ? '0 : timerCountA + 1'b1;
			if ((timerClear && timerSelect) || timerCountB == 16'h00ff)
				timerCountB <= '0;
			else
				timerCountB <= timerCountB + 1'b1;
		end
	end
endmodule : ccpu_partner
`default_nettype wire

//--- sim/tb_top.sv
// Purpose: Register-level tests of capture, compare and PWM
// Assumes: Default mode encodings; one quarter step per sys_clk at prescale 1
// Notes:   Each bus task leaves a gap cycle so strobes never merge
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin \
	miscompares++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb_top;
	logic sys_clk, nrst, regWr, regRd, pinDrive;
	logic [2:0] regAddr;
	logic [15:0] regWdata, regRdata, timerCountA, timerCountB, tr, tf, ex;
	logic timerSelect, timerClear, specialEvent, postEvent;
	logic unitPinIn, unitPinOut, unitPinOe, unitIrq;
	int testsRun = 0;
	int miscompares = 0;
	int hi;
	int capN [4] = '{1, 1, 4, 16};
	logic [3:0] capMode [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
	logic [3:0] cmpMode [5] = '{4'h8, 4'h9, 4'h2, 4'ha, 4'h2};
	logic cmpPin [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [15:0] tcon [5] = '{16'h4, 16'h4, 16'h4, 16'h5, 16'h7c};
	logic [9:0] duty [5] = '{10'h6, 10'h0, 10'h3ff, 10'h6, 10'h6};
	int hiExp [5] = '{6, 0, 16, 24, 6};
	int per [5] = '{16, 16, 16, 64, 16};
	ccpu_unit dut (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .timerCountA(timerCountA),
		.timerCountB(timerCountB), .timerSelect(timerSelect),
		.timerClear(timerClear), .specialEvent(specialEvent),
		.postEvent(postEvent), .unitPinIn(unitPinIn),
		.unitPinOut(unitPinOut), .unitPinOe(unitPinOe), .unitIrq(unitIrq));
	ccpu_partner far (.sys_clk(sys_clk), .nrst(nrst),
		.timerSelect(timerSelect), .timerClear(timerClear),
		.pinDrive(pinDrive), .unitPinOut(unitPinOut), .unitPinOe(unitPinOe),
		.timerCountA(timerCountA), .timerCountB(timerCountB),
		.unitPinIn(unitPinIn));
	// ------------------------------------------------------------
	// Bus and pin tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rdx(input logic [2:0] a, input logic [15:0] e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		@(posedge sys_clk);
		`CHK(regRdata, e)
	endtask : rdx
	// One pin pulse; timer values at the edges the unit samples
	task automatic pulse(output logic [15:0] r, output logic [15:0] f);
		pinDrive <= 1'b1;
		@(posedge sys_clk);
		r = timerCountA;
		@(posedge sys_clk);
		pinDrive <= 1'b0;
		@(posedge sys_clk);
		f = timerCountA;
		@(posedge sys_clk);
	endtask : pulse
	// Bounded wait for the gated flag
	task automatic waitIrq;
		int n;
		n = 0;
		while (unitIrq !== 1'b1 && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
		`CHK(unitIrq, 1'b1)
	endtask : waitIrq
	task automatic results;
		$display("comparisons %0d mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	// Clock at 200 MHz
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Hang guard, far beyond the few thousand cycles of the tests
	initial begin
		#100000;
		miscompares++;
		results();
	end
	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		{regAddr, regWdata, regWr, regRd, pinDrive, nrst} = '0;
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		rdx(ccpu_pkg::REG_PER, 16'h00ff);
		rdx(ccpu_pkg::REG_CTRL, 16'h0000);
		`CHK(unitPinOe, 1'b0)
		// Each prescaler entered through a zero write, flag cleared
		for (int i = 0; i < 4; i++) begin
			wr(ccpu_pkg::REG_CTRL, 16'h0000);
			wr(ccpu_pkg::REG_CTRL, {12'h0, capMode[i]});
			wr(ccpu_pkg::REG_IRQ, 16'h0002);
			// Second capture lands before any read
			for (int k = 0; k < 2; k++) begin
				repeat (capN[i] - 1) pulse(tr, tf);
				`CHK(unitIrq, 1'(k))
				pulse(tr, tf);
			end
			`CHK(unitIrq, 1'b1)
			ex = (i == 0) ? tf : tr;
			rdx(ccpu_pkg::REG_VLO, {8'h00, ex[7:0]});
			rdx(ccpu_pkg::REG_VHI, {8'h00, ex[15:8]});
		end
		$display("capture test done");
		wr(ccpu_pkg::REG_CTRL, 16'h0000);
		wr(ccpu_pkg::REG_TSEL, 16'h0001);
		`CHK(timerSelect, 1'b1)
		wr(ccpu_pkg::REG_VLO, 16'h0040);
		wr(ccpu_pkg::REG_VHI, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			while (timerCountB !== 16'h0080) @(posedge sys_clk);
			wr(ccpu_pkg::REG_CTRL, {12'h0, cmpMode[i]});
			wr(ccpu_pkg::REG_IRQ, 16'h0002);
			waitIrq();
			`CHK(unitPinOut, cmpPin[i])
			`CHK(unitPinOe, 1'b1)
		end
		wr(ccpu_pkg::REG_IRQ, 16'h0006);
		wr(ccpu_pkg::REG_CTRL, 16'h0003);
		// Pin takes the latch one cycle after the mode lands
		@(posedge sys_clk);
		`CHK(unitPinOut, 1'b1)
		wr(ccpu_pkg::REG_CTRL, 16'h000b);
		while (timerClear !== 1'b1) @(posedge sys_clk);
		`CHK(specialEvent, 1'b1)
		@(posedge sys_clk);
		`CHK(timerCountB, 16'h0000)
		wr(ccpu_pkg::REG_CTRL, 16'h0000);
		`CHK(unitPinOe, 1'b0)
		$display("compare test done");
		wr(ccpu_pkg::REG_PER, 16'h0003);
		for (int i = 0; i < 5; i++) begin
			wr(ccpu_pkg::REG_VLO, {8'h00, duty[i][9:2]});
			wr(ccpu_pkg::REG_CTRL, {10'h0, duty[i][1:0], 4'hc});
			wr(ccpu_pkg::REG_TCON, tcon[i]);
			repeat (150) @(posedge sys_clk);
			hi = 0;
			repeat (per[i]) begin
				@(posedge sys_clk);
				hi += (unitPinOut === 1'b1);
			end
			`CHK(hi, hiExp[i])
			if (i == 0) begin
				// Stop the timer so no rollover can hide a landed write
				wr(ccpu_pkg::REG_TCON, 16'h0000);
				wr(ccpu_pkg::REG_VHI, 16'h00aa);
				rdx(ccpu_pkg::REG_VHI, 16'h0001);
			end
			// Postscale 16 gives one pulse per 256 cycles
			if (i == 4) begin
				hi = 0;
				repeat (256) begin
					@(posedge sys_clk);
					hi += (postEvent === 1'b1);
				end
				`CHK(hi, 1)
			end
		end
		$display("pwm test done");
		results();
	end
endmodule : tb_top
`default_nettype wire
